// ==== logic/sbsc_ctrl.sv ====
// control logic of a synchronous burst sram without bus turnaround
// assumes pins arrive unsynchronised; the array has a combinational read
// port and a queued write port; tri-state is resolved outside
`timescale 1ns/1ps
`default_nettype none
`include "sbsc_consts.svh"
module sbsc_ctrl
	import sbsc_pkg::*;
#(
	parameter int AW = 20,
	parameter int DW = 36,
	parameter int NB = 4,
	parameter int FD = 16
) (
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic i_clock_gate_n,
	input wire logic i_advance_load,
	input wire logic i_store_select,
	input wire logic [NB-1:0] i_byte_lane_enables_n,
	input wire logic i_chip_select_a_n,
	input wire logic i_chip_select_b,
	input wire logic i_chip_select_c_n,
	input wire logic i_out_drive_n,
	input wire logic i_sleep_request,
	input wire logic i_unregistered_out_n,
	input wire logic i_order_select_n,
	input wire logic [AW-1:0] i_addr,
	input wire logic [DW-1:0] i_dq_i,
	output logic [DW-1:0] o_dq_o,
	output logic o_dq_oe,
	output logic o_rd_en,
	output logic [AW-1:0] o_rd_addr,
	input wire logic [DW-1:0] i_rd_data,
	output logic o_wr_valid,
	input wire logic i_wr_ready,
	output logic [AW-1:0] o_wr_addr,
	output logic [NB-1:0] o_wr_byte_en,
	output logic [DW-1:0] o_wr_data,
	output logic o_accept,
	output logic o_sleeping
);
	localparam int QW = AW + NB + DW;
	localparam logic [1:0] SLEEP_LAST = 2'(`SBSC_SLEEP_ENTRY_CYC - 2);
	localparam logic [1:0] WAKE_LAST = 2'(`SBSC_WAKE_CYC - 1);

	typedef struct packed {
		logic cke_n;
		logic advance_load;
		logic store;
		logic [NB-1:0] be_n;
		logic csa_n;
		logic csb;
		logic csc_n;
		logic zz;
		logic ft_n;
		logic order_n;
		logic [AW-1:0] addr;
		logic [DW-1:0] dq;
	} sbsc_pin_s;

	typedef struct packed {
		sbsc_pin_s s1;
		sbsc_pin_s s2;
		sbsc_burst_e btype;
		logic [AW-1:0] base;
		logic [1:0] start;
		logic [1:0] step;
		logic cmd_v;
		logic cmd_wr;
		logic [AW-1:0] cmd_addr;
		logic [NB-1:0] cmd_be_n;
		logic w2_v;
		logic [AW-1:0] w2_addr;
		logic [NB-1:0] w2_be_n;
		logic rd1_v;
		logic [DW-1:0] rd1;
		logic drv;
		logic [DW-1:0] dq_o;
		sbsc_pwr_e pwr;
		logic [1:0] pcnt;
	} sbsc_state_s;

	sbsc_state_s st_r;
	sbsc_state_s st_nxt;
	sbsc_pin_s pins;
	sbsc_pin_s p;
	logic sel;
	logic flow;
	logic [1:0] nstep;
	logic [1:0] nlow;
	logic push;
	logic [AW-1:0] push_addr;
	logic [NB-1:0] push_be_n;
	logic q_valid;
	logic q_ready;
	logic base_stall;
	logic stall;
	logic [QW-1:0] q_out;

	// every pin except the output enable passes two flops before use
	assign pins = '{cke_n: i_clock_gate_n, advance_load: i_advance_load, store: i_store_select,
		be_n: i_byte_lane_enables_n, csa_n: i_chip_select_a_n, csb: i_chip_select_b,
		csc_n: i_chip_select_c_n, zz: i_sleep_request, ft_n: i_unregistered_out_n,
		order_n: i_order_select_n, addr: i_addr, dq: i_dq_i};
	assign p = st_r.s2;

	assign sel = !p.csa_n && p.csb && !p.csc_n;
	assign flow = !p.ft_n;
	assign nstep = st_r.step + `SBSC_BURST_STEP;
	// interleaved: start xor count, linear: start plus count
	assign nlow = p.order_n ? (st_r.start ^ nstep) : (st_r.start + nstep);

	// write data taken one edge after the command in flow-through, two in pipelined
	always_comb begin
		if (flow) begin
			push = st_r.cmd_v && st_r.cmd_wr && !(&st_r.cmd_be_n);
			push_addr = st_r.cmd_addr;
			push_be_n = st_r.cmd_be_n;
		end else begin
			push = st_r.w2_v && !(&st_r.w2_be_n);
			push_addr = st_r.w2_addr;
			push_be_n = st_r.w2_be_n;
		end
	end

	assign base_stall = p.cke_n || (st_r.pwr == SBSC_ASLEEP);
	assign q_valid = push && !base_stall;
	assign stall = base_stall || (push && !q_ready);

	always_comb begin
		st_nxt = st_r;
		st_nxt.s1 = pins;
		st_nxt.s2 = st_r.s1;
		// sleep sequencing runs even while the clock gate is high
		case (st_r.pwr)
			SBSC_AWAKE: begin
				if (p.zz) begin
					st_nxt.pwr = SBSC_ENTERING;
					st_nxt.pcnt = 2'h0;
				end
			end
			SBSC_ENTERING: begin
				if (!p.zz) begin
					st_nxt.pwr = SBSC_AWAKE;
				end else if (st_r.pcnt == SLEEP_LAST) begin
					st_nxt.pwr = SBSC_ASLEEP;
				end else begin
					st_nxt.pcnt = st_r.pcnt + 2'h1;
				end
			end
			SBSC_ASLEEP: begin
				if (!p.zz) begin
					st_nxt.pwr = SBSC_WAKING;
					st_nxt.pcnt = 2'h0;
				end
			end
			SBSC_WAKING: begin
				if (p.zz) begin
					st_nxt.pwr = SBSC_ASLEEP;
				end else if (st_r.pcnt == WAKE_LAST) begin
					st_nxt.pwr = SBSC_AWAKE;
				end else begin
					st_nxt.pcnt = st_r.pcnt + 2'h1;
				end
			end
			default: begin
				st_nxt.pwr = SBSC_AWAKE;
			end
		endcase
		if (!stall) begin
			st_nxt.cmd_v = 1'b0;
			st_nxt.cmd_wr = 1'b0;
			if (!p.advance_load) begin
				// a write start while recovering from sleep is treated as a deselect
				if (sel && !(st_r.pwr == SBSC_WAKING && !p.store)) begin
					st_nxt.base = p.addr;
					st_nxt.start = p.addr[1:0];
					st_nxt.step = 2'h0;
					st_nxt.btype = p.store ? SBSC_READ : SBSC_WRITE;
					st_nxt.cmd_v = 1'b1;
					st_nxt.cmd_wr = !p.store;
					st_nxt.cmd_addr = p.addr;
					st_nxt.cmd_be_n = p.be_n;
				end else begin
					st_nxt.btype = SBSC_DESEL;
				end
			end else if (st_r.btype != SBSC_DESEL) begin
				st_nxt.step = nstep;
				st_nxt.cmd_v = 1'b1;
				st_nxt.cmd_wr = st_r.btype == SBSC_WRITE;
				st_nxt.cmd_addr = {st_r.base[AW-1:`SBSC_LOW_BITS], nlow};
				st_nxt.cmd_be_n = p.be_n;
			end
			st_nxt.w2_v = st_r.cmd_v && st_r.cmd_wr;
			st_nxt.w2_addr = st_r.cmd_addr;
			st_nxt.w2_be_n = st_r.cmd_be_n;
			st_nxt.rd1_v = st_r.cmd_v && !st_r.cmd_wr;
			st_nxt.rd1 = i_rd_data;
			if (flow) begin
				st_nxt.drv = st_r.cmd_v && !st_r.cmd_wr;
				if (st_r.cmd_v && !st_r.cmd_wr) begin
					st_nxt.dq_o = i_rd_data;
				end
			end else begin
				st_nxt.drv = st_r.rd1_v;
				if (st_r.rd1_v) begin
					st_nxt.dq_o = st_r.rd1;
				end
			end
		end
	end

	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign o_dq_o = st_r.dq_o;
	// output enable floats the pins without waiting for an edge
	assign o_dq_oe = st_r.drv && !i_out_drive_n && (st_r.pwr != SBSC_ASLEEP);
	assign o_rd_en = st_r.cmd_v && !st_r.cmd_wr;
	assign o_rd_addr = st_r.cmd_addr;
	assign o_accept = !stall;
	assign o_sleeping = st_r.pwr == SBSC_ASLEEP;

	sbsc_fifo #(
		.W(QW),
		.D(FD)
	) u_wq (
		.i_clk(i_clk),
		.i_rst_n(i_rst_n),
		.i_in_valid(q_valid),
		.o_in_ready(q_ready),
		.i_in_data({push_addr, ~push_be_n, p.dq}),
		.o_out_valid(o_wr_valid),
		.i_out_ready(i_wr_ready),
		.o_out_data(q_out)
	);
	assign o_wr_addr = q_out[QW-1:NB+DW];
	assign o_wr_byte_en = q_out[NB+DW-1:DW];
	assign o_wr_data = q_out[DW-1:0];

	// checks
	logic cont;
	assign cont = !stall && p.advance_load && st_r.btype != SBSC_DESEL;

	sequence s_zz_hold;
		st_r.pwr == SBSC_AWAKE && p.zz ##1 p.zz;
	endsequence
	sequence s_pipe_read;
		st_r.cmd_v && !st_r.cmd_wr && !flow && !stall ##1 !stall && !flow;
	endsequence

	a_abort_no_store: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		o_wr_valid |-> (|o_wr_byte_en))
		else $error("write with no byte lane queued");
	a_desel_no_load: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		(!stall && !p.advance_load && !sel) |=> (st_r.btype == SBSC_DESEL && !st_r.cmd_v
		&& $stable(st_r.base)))
		else $error("deselect did not deselect");
	a_cont_keeps_type: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		cont |=> (st_r.btype == $past(st_r.btype) && st_r.cmd_wr == ($past(st_r.btype)
		== SBSC_WRITE)))
		else $error("continue changed burst type");
	a_cont_increments: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		cont |=> st_r.step == 2'($past(st_r.step) + 2'h1))
		else $error("counter not advanced");
	a_burst_wrap: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		(cont && st_r.step == 2'h3) |=> st_r.cmd_addr[1:0] == st_r.start)
		else $error("burst did not wrap to start");
	a_linear_order: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		(cont && !p.order_n) |=> st_r.cmd_addr[1:0] == 2'(st_r.start + st_r.step))
		else $error("linear order broken");
	a_interleave_order: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		(cont && p.order_n) |=> st_r.cmd_addr[1:0] == (st_r.start ^ st_r.step))
		else $error("interleaved order broken");
	a_stall_holds_out: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		base_stall |=> ($stable(st_r.dq_o) && $stable(st_r.drv) && $stable(st_r.step)))
		else $error("state moved during stall");
	a_sleep_entry: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		s_zz_hold |=> st_r.pwr == SBSC_ASLEEP)
		else $error("sleep not entered after two cycles");
	a_sleep_float: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		st_r.pwr == SBSC_ASLEEP |-> !o_dq_oe)
		else $error("pins driven while asleep");
	a_pipe_read_out: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		s_pipe_read |=> st_r.drv)
		else $error("pipelined read data not driven");
	a_write_off: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		(st_r.cmd_v && st_r.cmd_wr && flow && !stall) |=> !st_r.drv)
		else $error("drivers on during write");

	// burst starts and address loading
	a_read_start: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		(!stall && !p.advance_load && sel && p.store) |=> (st_r.btype == SBSC_READ && st_r.cmd_v
		&& !st_r.cmd_wr && st_r.cmd_addr == $past(p.addr)))
		else $error("read burst not started");
	a_write_start: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		(!stall && !p.advance_load && sel && !p.store && st_r.pwr != SBSC_WAKING) |=>
		(st_r.btype == SBSC_WRITE && st_r.cmd_v && st_r.cmd_wr && st_r.cmd_be_n == $past(p.be_n)))
		else $error("write burst not started");
	a_load_takes_addr: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		(!stall && !p.advance_load && sel && p.store) |=> (st_r.base == $past(p.addr) && st_r.step == 2'h0))
		else $error("load did not take the address");
	a_cont_same_base: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		cont |=> st_r.cmd_addr[AW-1:`SBSC_LOW_BITS] == st_r.base[AW-1:`SBSC_LOW_BITS])
		else $error("continue left the burst block");

	// read and write data timing
	a_flow_read_out: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		(st_r.cmd_v && !st_r.cmd_wr && flow && !stall) |=> (st_r.drv
		&& st_r.dq_o == $past(i_rd_data)))
		else $error("flow-through read data wrong");
	a_pipe_read_data: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		s_pipe_read |=> st_r.dq_o == $past(i_rd_data, 2))
		else $error("pipelined read data wrong");
	a_flow_write_queued: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		(flow && !stall && st_r.cmd_v && st_r.cmd_wr && !(&st_r.cmd_be_n)) |=> o_wr_valid)
		else $error("flow-through write not queued");
	a_pipe_write_queued: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		(!flow && !stall && st_r.w2_v && !(&st_r.w2_be_n)) |=> o_wr_valid)
		else $error("pipelined write not queued");

	// quiet states
	sequence s_desel_flow;
		(!stall && !p.advance_load && !sel && flow) ##1 (!stall && flow);
	endsequence
	sequence s_wake;
		(st_r.pwr == SBSC_ASLEEP && !p.zz) ##1 !p.zz ##1 !p.zz;
	endsequence
	a_reset_quiet: assert property (@(posedge i_clk)
		!i_rst_n |=> (!o_dq_oe && !o_rd_en && !o_wr_valid && !o_sleeping))
		else $error("outputs active after reset");
	a_desel_float: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		s_desel_flow |=> !st_r.drv)
		else $error("pins driven after deselect");
	a_gate_freezes: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		p.cke_n |=> ($stable(st_r.cmd_v) && $stable(st_r.cmd_addr) && $stable(st_r.btype)))
		else $error("command moved on an ignored edge");
	a_asleep_ignores: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		st_r.pwr == SBSC_ASLEEP |=> ($stable(st_r.cmd_v) && $stable(st_r.base)
		&& $stable(st_r.w2_v)))
		else $error("state moved while asleep");
	a_wake_recovery: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		s_wake |=> st_r.pwr == SBSC_AWAKE)
		else $error("wake recovery length wrong");
endmodule : sbsc_ctrl
`default_nettype wire

// ==== logic/sbsc_consts.svh ====
// timing and burst constants of the synchronous burst sram control block
// assumes a 100 MHz core clock; included by the package and the control module
`ifndef SBSC_CONSTS_SVH
`define SBSC_CONSTS_SVH
`define SBSC_CLK_PERIOD_NS 10
`define SBSC_WAKE_RECOVERY_NS 20
`define SBSC_WAKE_CYC ((`SBSC_WAKE_RECOVERY_NS + `SBSC_CLK_PERIOD_NS - 1) / `SBSC_CLK_PERIOD_NS)
`define SBSC_SLEEP_ENTRY_CYC 2
`define SBSC_BURST_STEP 2'h1
`define SBSC_LOW_BITS 2
`endif

// ==== logic/sbsc_pkg.sv ====
// types shared by the burst sram control block
// assumes sbsc_consts.svh on the include path
`include "sbsc_consts.svh"
package sbsc_pkg;
	typedef enum logic [1:0] {
		SBSC_DESEL = 2'b00,
		SBSC_READ = 2'b01,
		SBSC_WRITE = 2'b10
	} sbsc_burst_e;
	typedef enum logic [1:0] {
		SBSC_AWAKE = 2'b00,
		SBSC_ENTERING = 2'b01,
		SBSC_ASLEEP = 2'b10,
		SBSC_WAKING = 2'b11
	} sbsc_pwr_e;
endpackage : sbsc_pkg

// ==== logic/sbsc_fifo.sv ====
// write queue between the burst control and the memory array port
// assumes one clock shared with its source and its drain
`timescale 1ns/1ps
`default_nettype none
module sbsc_fifo #(
	parameter int W = 8,
	parameter int D = 16
) (
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic i_in_valid,
	output logic o_in_ready,
	input wire logic [W-1:0] i_in_data,
	output logic o_out_valid,
	input wire logic i_out_ready,
	output logic [W-1:0] o_out_data
);
	localparam int PW = $clog2(D);
	typedef struct packed {
		logic [PW:0] wp;
		logic [PW:0] rp;
	} sbsc_fifo_s;
	sbsc_fifo_s st_r;
	sbsc_fifo_s st_nxt;
	logic [W-1:0] mem [D];
	logic full;
	logic empty;
	logic push;
	logic pop;

	assign empty = st_r.wp == st_r.rp;
	assign full = (st_r.wp[PW-1:0] == st_r.rp[PW-1:0]) && (st_r.wp[PW] != st_r.rp[PW]);
	assign push = i_in_valid && !full;
	assign pop = o_out_valid && i_out_ready;
	assign o_in_ready = !full;
	assign o_out_valid = !empty;
	assign o_out_data = mem[st_r.rp[PW-1:0]];

	always_comb begin
		st_nxt = st_r;
		if (push) begin
			st_nxt.wp = st_r.wp + 1'b1;
		end
		if (pop) begin
			st_nxt.rp = st_r.rp + 1'b1;
		end
	end

	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	always_ff @(posedge i_clk) begin
		if (push) begin
			mem[st_r.wp[PW-1:0]] <= i_in_data;
		end
	end
endmodule : sbsc_fifo
`default_nettype wire

// ==== verification/sbsc_host.sv ====
// host controller model: one pin cycle per call, write data trails it
// assumes the bench clock; control pins move 1 ns after each rising edge, write data on the edge
`timescale 1ns/1ps
`default_nettype none
module sbsc_host (
	input wire logic i_clk,
	input wire logic i_pipe,
	output logic o_cke_n,
	output logic o_adv,
	output logic o_st,
	output logic [3:0] o_be_n,
	output logic o_cs_a_n,
	output logic o_cs_b,
	output logic o_cs_c_n,
	output logic [19:0] o_addr,
	output logic [35:0] o_dq
);
	logic [35:0] wd = '0;
	logic [35:0] d0 = '0;
	logic [35:0] d1 = '0;
	assign o_dq = i_pipe ? d1 : d0;
	// an ignored edge does not move the write data
	always @(posedge i_clk) begin
		if (!o_cke_n) d0 <= wd;
		if (!o_cke_n) d1 <= d0;
	end
	initial begin
		o_cke_n = 1'b0;
		o_adv = 1'b0;
		o_st = 1'b1;
		o_be_n = 4'hf;
		{o_cs_a_n, o_cs_b, o_cs_c_n} = 3'b110;
		o_addr = '0;
	end
	// sel 0 selects, 1..3 drops one select
	task automatic cmd(input logic ck, input logic advance_load, input logic st, input logic [3:0] be,
		input logic [1:0] sel, input logic [19:0] a, input logic [35:0] d);
		@(posedge i_clk);
		#1;
		o_cke_n = ck;
		o_adv = advance_load;
		o_st = st;
		o_be_n = be;
		o_cs_a_n = sel == 2'd1;
		o_cs_b = sel != 2'd2;
		o_cs_c_n = sel == 2'd3;
		o_addr = a;
		wd = d;
	endtask : cmd
endmodule : sbsc_host
`default_nettype wire

// ==== verification/tb.sv ====
// self-checking bench of the burst sram control block
// assumes sbsc_host on the pins and a behavioural array here
`timescale 1ns/1ps
`default_nettype none
module tb;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic pipe = 1'b1;
	logic order = 1'b0;
	logic oe_n = 1'b0;
	logic sleep = 1'b0;
	logic rdy_en = 1'b1;
	logic wr_ready = 1'b0;
	logic lossy = 1'b0;
	wire logic ck_n, advance_load, st, cs_a_n, cs_b, cs_c_n;
	wire logic [3:0] be_n;
	wire logic [19:0] addr;
	wire logic [35:0] dq;
	logic [35:0] dq_o, rd_data, wr_data;
	logic [19:0] rd_addr, wr_addr;
	logic [3:0] wr_be;
	logic dq_oe, rd_en, wr_valid, accept, sleeping;
	int miscompares = 0;
	int checked = 0;
	int refusals = 0;
	int drained = 0;
	logic pv [2] = '{1'b0, 1'b0};
	logic [35:0] pd [2];
	logic [19:0] rq [$];
	logic [59:0] wq [$];
	always #5 clk = ~clk;
	sbsc_host host (.i_clk(clk), .i_pipe(pipe), .o_cke_n(ck_n), .o_adv(advance_load), .o_st(st),
		.o_be_n(be_n), .o_cs_a_n(cs_a_n), .o_cs_b(cs_b), .o_cs_c_n(cs_c_n), .o_addr(addr),
		.o_dq(dq));
	sbsc_ctrl uut (.i_clk(clk), .i_rst_n(rst_n), .i_clock_gate_n(ck_n), .i_advance_load(advance_load),
		.i_store_select(st), .i_byte_lane_enables_n(be_n), .i_chip_select_a_n(cs_a_n),
		.i_chip_select_b(cs_b), .i_chip_select_c_n(cs_c_n), .i_out_drive_n(oe_n),
		.i_sleep_request(sleep), .i_unregistered_out_n(pipe), .i_order_select_n(order),
		.i_addr(addr), .i_dq_i(dq), .o_dq_o(dq_o), .o_dq_oe(dq_oe), .o_rd_en(rd_en),
		.o_rd_addr(rd_addr), .i_rd_data(rd_data), .o_wr_valid(wr_valid),
		.i_wr_ready(wr_ready), .o_wr_addr(wr_addr), .o_wr_byte_en(wr_be),
		.o_wr_data(wr_data), .o_accept(accept), .o_sleeping(sleeping));
	function automatic logic [19:0] nxt(logic [19:0] s, int k);
		return {s[19:2], order ? s[1:0] ^ 2'(k) : s[1:0] + 2'(k)};
	endfunction : nxt
	function automatic logic [35:0] rdf(logic [19:0] a);
		return {a[15:0] ^ 16'ha5c3, a};
	endfunction : rdf
	function automatic logic [35:0] lanes(logic [3:0] be);
		return {{9{be[3]}}, {9{be[2]}}, {9{be[1]}}, {9{be[0]}}};
	endfunction : lanes
	assign rd_data = rdf(rd_addr);
	task automatic cmp(logic [63:0] g, logic [63:0] e);
		checked++;
		if (g !== e) begin
			miscompares++;
			$display("mismatch t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask : cmp
	task automatic summarize();
		$display("checked=%0d miscompares=%0d", checked, miscompares);
		if (miscompares == 0 && checked > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : summarize
	task automatic idle(int n);
		repeat (n) host.cmd(1'b0, 1'b0, 1'b1, 4'($urandom), 2'd1, 20'($urandom), '0);
	endtask : idle
	task automatic burst(logic rd, int n);
		logic [19:0] s;
		logic [3:0] be;
		logic [35:0] d;
		s = 20'($urandom);
		for (int k = 0; k < n; k++) begin
			if ($urandom % 5 == 0) host.cmd(1'b1, 1'b0, 1'b1, 4'h0, 2'd0, ~s, '1);
			be = (k == 1) ? 4'hf : 4'($urandom);
			d = 36'({$urandom, $urandom});
			host.cmd(1'b0, k != 0, k ? 1'($urandom) : rd, be,
				k ? 2'($urandom) : 2'd0, s, d);
			if (rd) rq.push_back(nxt(s, k));
			else if (be != 4'hf) wq.push_back({nxt(s, k), ~be, d & lanes(~be)});
		end
	endtask : burst
	// array side: read port and write queue drain
	always @(posedge clk) begin
		#1;
		wr_ready = rdy_en & 1'($urandom);
	end
	always @(posedge clk) begin
		if (rst_n) begin
			if (pv[pipe] && !oe_n) cmp(dq_o, pd[pipe]);
			cmp(dq_oe, pv[pipe] & ~oe_n);
			if (accept === 1'b1) begin
				pv[1] = pv[0];
				pd[1] = pd[0];
				pv[0] = rd_en;
				pd[0] = rdf(rd_addr);
				if (rd_en === 1'b1) cmp(rd_addr, rq.pop_front());
			end else begin
				refusals++;
			end
			if (wr_valid === 1'b1 && wr_ready) begin
				while (lossy && wq.size() > 1 && wq[0][59:40] !== wr_addr) void'(wq.pop_front());
				drained++;
				cmp({wr_addr, wr_be, wr_data & lanes(wr_be)}, wq.pop_front());
			end
		end
	end
	initial begin
		int n;
		void'($urandom(32'h5c365d1d));
		repeat (10) @(posedge clk);
		#1;
		cmp({dq_oe, rd_en, wr_valid, sleeping}, 4'h0);
		rst_n = 1'b1;
		for (int m = 0; m < 8; m++) begin
			idle(8);
			{oe_n, order, pipe} = 3'(m);
			idle(4);
			repeat (3) begin
				burst(1'b1, 5);
				burst(1'b0, 5);
			end
		end
		for (int s = 1; s < 4; s++) begin
			host.cmd(1'b0, 1'b0, 1'(s), 4'h0, 2'(s), 20'($urandom), '0);
			host.cmd(1'b0, 1'b1, 1'($urandom), 4'h0, 2'd0, '0, '0);
		end
		idle(8);
		oe_n = 1'b0;
		sleep = 1'b1;
		n = 0;
		while (sleeping !== 1'b1 && n < 20) begin
			idle(1);
			n++;
		end
		cmp(n >= 2 && n <= 6, 1'b1);
		repeat (4) begin
			host.cmd(1'b0, 1'b0, 1'b1, 4'h0, 2'd0, 20'($urandom), '0);
			cmp({rd_en, dq_oe, sleeping}, 3'b001);
		end
		idle(2);
		sleep = 1'b0;
		idle(6);
		burst(1'b1, 5);
		rdy_en = 1'b0;
		lossy = 1'b1;
		idle(6);
		refusals = 0;
		drained = 0;
		for (int k = 0; k < 20; k++) begin
			host.cmd(1'b0, 1'b0, 1'b0, 4'h0, 2'd0, 20'(k * 4), '0);
			wq.push_back({20'(k * 4), 4'hf, 36'h0});
		end
		idle(4);
		cmp(refusals > 0, 1'b1);
		rdy_en = 1'b1;
		idle(80);
		cmp({wr_valid, 1'(drained >= 16)}, 2'b01);
		lossy = 1'b0;
		wq.delete();
		idle(10);
		cmp(rq.size() + wq.size(), 0);
		summarize();
	end
	initial begin
		#200000;
		miscompares++;
		summarize();
	end
endmodule : tb
`default_nettype wire
